// File: shared/monstat_pkg.sv
/*
  Constants of the supply-monitor status and enable register bank: register offsets,
  field positions, reset values and self-test timing.
  Assumes a single 100 MHz system clock and an 8-bit register port from the serial engine.
*/
package monstat_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] MONSTAT_STATUS_OFFS = 8'h02;
  localparam logic [7:0] MONSTAT_MONEN_OFFS = 8'h03;

  // ----------------------------------------------------------------------------
  // Field positions of the status register.
  // ----------------------------------------------------------------------------
  localparam int MONSTAT_CLOCK_FAULT_FLAG_BIT = 7;
  localparam int MONSTAT_PARF_BIT = 6;
  localparam int MONSTAT_FSUM_BIT = 5;
  localparam int MONSTAT_RSTLVL_BIT = 4;
  localparam int MONSTAT_EN1_BIT = 3;
  localparam int MONSTAT_EN0_BIT = 2;
  localparam int MONSTAT_OVST_BIT = 1;
  localparam int MONSTAT_UVST_BIT = 0;

  // ----------------------------------------------------------------------------
  // Field positions of the monitor enable register.
  // ----------------------------------------------------------------------------
  localparam int MONSTAT_PDEN_BIT = 7;
  localparam int MONSTAT_NUM_CH = 7;

  // ----------------------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] MONSTAT_MONEN_RESET = 8'h7F;
  localparam logic [7:0] MONSTAT_RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------------------
  // Self-test timing.
  // ----------------------------------------------------------------------------
  localparam int MONSTAT_CLK_PERIOD_PS = 10000;
  localparam int MONSTAT_BIST_TYP_PS = 60000000;
  localparam int MONSTAT_BIST_MAX_PS = 72200000;
  // Longest time, so the count rounds down.
  localparam int MONSTAT_BIST_MAX_CYC = MONSTAT_BIST_MAX_PS / MONSTAT_CLK_PERIOD_PS;

  // ----------------------------------------------------------------------------
  // Input synchroniser layout.
  // ----------------------------------------------------------------------------
  localparam int MONSTAT_NSYNC = 5;
  localparam int MONSTAT_SY_FAULT = 0;
  localparam int MONSTAT_SY_RSTPIN = 1;
  localparam int MONSTAT_SY_EN0 = 2;
  localparam int MONSTAT_SY_EN1 = 3;
  localparam int MONSTAT_SY_SUPPLY = 4;
  localparam logic [MONSTAT_NSYNC-1:0] MONSTAT_SYNC_RESET = 5'h00;

  typedef enum logic [2:0] {
    MONSTAT_BIST_IDLE = 3'b001,
    MONSTAT_BIST_RUN = 3'b010,
    MONSTAT_BIST_DONE = 3'b100
  } monstat_bist_t;

endpackage

// File: design/monstat_regs.sv
/*
  Status and voltage-monitor enable registers of a seven-input supply monitor, with the
  comparator power-down control and the comparator self-test sequencer.
  Assumes the serial protocol engine presents byte reads and writes on a simple register port,
  and that the analog comparators accept the enable outputs of this block.
*/
// Summary of operation
// RULE_01 - Fault summary flag is 1 whenever a fault would pull reset low.
// RULE_02 - Fault summary flag reads 0 without fault, the inverse of reset level.
// RULE_03 - Over-voltage self-test bit reads 0 when all over-voltage comparators passed.
// RULE_04 - Over-voltage self-test bit reads 1 when any over-voltage comparator failed.
// RULE_05 - With power-down enabled, comparators turn off once enable-0 low and recording done.
// RULE_06 - Powered-down comparators turn back on at a rising edge of enable-0.
// RULE_07 - With power-down disabled, off-detection comparators stay enabled always.
// RULE_08 - With power-down disabled, over/under-voltage comparators are enabled as needed.
// RULE_09 - Seven channel enable bits 6..0; 1 enables that channel's monitoring.
// RULE_10 - Self-test starts on supply rising past lockout, done within 72.2 us.
// RULE_11 - Status bits are read-only: reset, enable pins, clock health, parity fault.
`timescale 1ns/100ps

module monstat_regs
  import monstat_pkg::*;
#(
  parameter int BIST_CYCLES = MONSTAT_BIST_MAX_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic fault_detect_i,
  input wire logic reset_pin_i,
  input wire logic sequence_enable_0_i,
  input wire logic sequence_enable_1_i,
  input wire logic supply_above_lockout_i,
  input wire logic clk_ok_i,
  input wire logic parity_err_i,
  input wire logic pd_record_done_i,
  input wire logic ov_bist_fail_i,
  input wire logic uv_bist_fail_i,
  output logic [MONSTAT_NUM_CH-1:0] ch_monitor_en_o,
  output logic off_cmp_en_o,
  output logic bist_active_o
);

  // ----------------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------------
  logic [MONSTAT_NSYNC-1:0] pins_raw;
  logic [MONSTAT_NSYNC-1:0] sy1_q;
  logic [MONSTAT_NSYNC-1:0] sy2_q;
  logic [MONSTAT_NSYNC-1:0] sy3_q;
  logic [MONSTAT_NSYNC-1:0] lvl_q;
  logic [MONSTAT_NSYNC-1:0] lvl_d;
  logic [MONSTAT_NSYNC-1:0] rise;

  assign pins_raw = {supply_above_lockout_i, sequence_enable_1_i, sequence_enable_0_i,
                     reset_pin_i, fault_detect_i};

  // A level is accepted only once the second and third stages agree, which filters a
  // metastable settle; the first stage feeds nothing but the second.
  genvar gi;
  generate
    for (gi = 0; gi < MONSTAT_NSYNC; gi++)
    begin : g_sync
      assign lvl_d[gi] = (sy2_q[gi] == sy3_q[gi]) ? sy3_q[gi] : lvl_q[gi];
      assign rise[gi] = lvl_d[gi] & ~lvl_q[gi];
    end
  endgenerate

  // Synchroniser stages and the filtered levels.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sy1_q <= MONSTAT_SYNC_RESET;
      sy2_q <= MONSTAT_SYNC_RESET;
      sy3_q <= MONSTAT_SYNC_RESET;
      lvl_q <= MONSTAT_SYNC_RESET;
    end
    else
    begin
      sy1_q <= pins_raw;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      lvl_q <= lvl_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Register decode and monitor enable register.
  // ----------------------------------------------------------------------------
  logic [7:0] monen_q;
  logic [7:0] monen_d;
  logic [7:0] status;
  logic [7:0] rdata_d;
  logic sel_monen;
  logic sel_status;

  assign sel_monen = (reg_addr_i == MONSTAT_MONEN_OFFS);
  assign sel_status = (reg_addr_i == MONSTAT_STATUS_OFFS);
  // Writes to the status offset fall through: the status has no storage. [RULE_11]
  assign monen_d = (reg_wr_i && sel_monen) ? reg_wdata_i : monen_q; // [RULE_09]
  assign rdata_d = !reg_rd_i ? reg_rdata_o :
                   sel_monen ? monen_q :
                   sel_status ? status : 8'h00;

  // Register storage and the registered read answer.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      monen_q <= MONSTAT_MONEN_RESET;
      reg_rdata_o <= MONSTAT_RDATA_RESET;
    end
    else
    begin
      monen_q <= monen_d;
      reg_rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Comparator power-down control.
  // ----------------------------------------------------------------------------
  logic pd_q;
  logic pd_d;
  logic pd_enter;
  logic en0_rise;

  assign en0_rise = rise[MONSTAT_SY_EN0];
  assign pd_enter = monen_q[MONSTAT_PDEN_BIT] & ~lvl_q[MONSTAT_SY_EN0] & pd_record_done_i;
  // Wake on the enable-0 edge has priority, so a low glitch cannot hold the monitor asleep.
  assign pd_d = !monen_q[MONSTAT_PDEN_BIT] ? 1'b0 : // [RULE_07]
                en0_rise ? 1'b0 : // [RULE_06]
                pd_enter ? 1'b1 : pd_q; // [RULE_05]

  // Power-down state and registered comparator enables.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pd_q <= 1'b0;
      off_cmp_en_o <= 1'b0;
      ch_monitor_en_o <= '0;
    end
    else
    begin
      pd_q <= pd_d;
      off_cmp_en_o <= ~pd_q; // [RULE_07]
      ch_monitor_en_o <= monen_q[MONSTAT_NUM_CH-1:0] & {MONSTAT_NUM_CH{~pd_q}}; // [RULE_08] [RULE_09]
    end
  end

  // ----------------------------------------------------------------------------
  // Comparator self-test sequencer.
  // ----------------------------------------------------------------------------
  monstat_bist_t bst_q;
  monstat_bist_t bst_d;
  logic [15:0] bcnt_q;
  logic [15:0] bcnt_d;
  logic bist_last;
  logic ovst_q;
  logic uvst_q;

  // The count stops one short of the limit so the result lands inside the longest time.
  assign bist_last = (bcnt_q == 16'(BIST_CYCLES - 1));
  assign bcnt_d = (bst_q == MONSTAT_BIST_RUN) ? bcnt_q + 16'h0001 : 16'h0000;

  // Next state of the self-test sequencer; a supply rise after a finished run starts it again, and one during a run is ignored.
  always_comb
  begin
    bst_d = bst_q;
    case (bst_q)
      MONSTAT_BIST_IDLE:
        if (rise[MONSTAT_SY_SUPPLY]) bst_d = MONSTAT_BIST_RUN; // [RULE_10]
      MONSTAT_BIST_RUN:
        if (bist_last) bst_d = MONSTAT_BIST_DONE; // [RULE_10]
      MONSTAT_BIST_DONE:
        if (rise[MONSTAT_SY_SUPPLY]) bst_d = MONSTAT_BIST_RUN;
      default:
        bst_d = MONSTAT_BIST_IDLE;
    endcase
  end

  // Sequencer state, count and the latched pass/fail results.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      bst_q <= MONSTAT_BIST_IDLE;
      bcnt_q <= 16'h0000;
      ovst_q <= 1'b0;
      uvst_q <= 1'b0;
      bist_active_o <= 1'b0;
    end
    else
    begin
      bst_q <= bst_d;
      bcnt_q <= bcnt_d;
      bist_active_o <= (bst_d == MONSTAT_BIST_RUN);
      if (bst_q == MONSTAT_BIST_RUN && bist_last)
      begin
        ovst_q <= ov_bist_fail_i; // [RULE_03] [RULE_04]
        uvst_q <= uv_bist_fail_i;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Status assembly.
  // ----------------------------------------------------------------------------
  // Live levels in bits 7..2, latched self-test results in bits 1..0; a 1 means a high pin or a fault. [RULE_11]
  assign status[MONSTAT_CLOCK_FAULT_FLAG_BIT] = ~clk_ok_i;
  assign status[MONSTAT_PARF_BIT] = parity_err_i;
  assign status[MONSTAT_FSUM_BIT] = lvl_q[MONSTAT_SY_FAULT]; // [RULE_01] [RULE_02]
  assign status[MONSTAT_RSTLVL_BIT] = lvl_q[MONSTAT_SY_RSTPIN];
  assign status[MONSTAT_EN1_BIT] = lvl_q[MONSTAT_SY_EN1];
  assign status[MONSTAT_EN0_BIT] = lvl_q[MONSTAT_SY_EN0];
  assign status[MONSTAT_OVST_BIT] = ovst_q; // [RULE_03] [RULE_04]
  assign status[MONSTAT_UVST_BIT] = uvst_q;

  // ----------------------------------------------------------------------------
  // Self-test length watch.
  // ----------------------------------------------------------------------------
  logic [15:0] bist_len_q;

  // Counts how long the busy output stays high, kept apart from the sequencer count so that
  // a wrong end-of-run compare cannot hide behind the very counter that it compares.
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      bist_len_q <= 16'h0000;
    end
    else
    begin
      bist_len_q <= bist_active_o ? bist_len_q + 16'h0001 : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------------
  AST_FSUM_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_01]
    reg_rd_i && sel_status |=> reg_rdata_o[MONSTAT_FSUM_BIT] == $past(lvl_q[MONSTAT_SY_FAULT]))
    else $error("Fault summary read-back does not follow the fault level.");

  AST_FSUM_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_02]
    !lvl_q[MONSTAT_SY_FAULT] && reg_rd_i && sel_status |=> !reg_rdata_o[MONSTAT_FSUM_BIT])
    else $error("Fault summary reads 1 without a fault.");

  AST_OV_RESULT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_03]
    bst_q == MONSTAT_BIST_RUN && bist_last |=> ovst_q == $past(ov_bist_fail_i))
    else $error("Over-voltage self-test result not latched.");

  AST_OV_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_04]
    bst_q == MONSTAT_BIST_DONE && !rise[MONSTAT_SY_SUPPLY] |=> $stable(ovst_q))
    else $error("Over-voltage self-test result changed after completion.");

  AST_PD_ENTER: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_05]
    pd_enter && !en0_rise |=> pd_q ##1 !off_cmp_en_o && ch_monitor_en_o == '0)
    else $error("Comparators not powered down.");

  AST_PD_WAKE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_06]
    pd_q && en0_rise |=> !pd_q ##1 off_cmp_en_o)
    else $error("Comparators not woken by enable-0 rising edge.");

  AST_OFF_ON: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_07]
    !monen_q[MONSTAT_PDEN_BIT] [*2] |=> off_cmp_en_o)
    else $error("Off comparators disabled while power-down option is clear.");

  AST_CH_EN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_09]
    reg_wr_i && sel_monen && !reg_wdata_i[MONSTAT_PDEN_BIT] |=> ##1
    ch_monitor_en_o == $past(reg_wdata_i[MONSTAT_NUM_CH-1:0], 2))
    else $error("Channel enables do not follow the written value.");

  AST_BIST_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_10]
    bist_len_q <= 16'(BIST_CYCLES))
    else $error("Self-test ran past its longest time.");

  AST_STATUS_RO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // [RULE_11]
    reg_wr_i && sel_status |=> monen_q == $past(monen_q))
    else $error("Write to the status offset altered a register.");

endmodule // monstat_regs

// File: test/monstat_host_model.sv
/*
  Host model standing in for the serial engine: single-byte reads and writes.
  Assumes the bench owns the clock and calls the tasks only after reset is released.
*/
`timescale 1ns/100ps

module monstat_host_model
(
  input wire logic sys_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  // ---------------------------------------------------------------
  // Bus tasks.
  // ---------------------------------------------------------------
  // Strobes last one cycle and change at the falling edge, clear of sampling.
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Stale data is inverted so it cannot pass for a fresh write.
  endtask

  // The answer is registered at the strobe's edge, so it is settled one half cycle later.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule // monstat_host_model

// File: test/monstat_regs_tb_top.sv
/*
  Self-checking bench for the status and monitor enable register bank.
  Assumes the host model drives the register port and the bench drives all pins.
*/
`timescale 1ns/100ps

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module monstat_regs_tb_top;
  import monstat_pkg::*;

  logic sys_clk_i, rst_n_i, fault, rpin, en0, en1, sup, clk_ok, par, pd_done, ovf, uvf;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, bist;
  logic [6:0] ch;
  logic off;
  int fails = 0;
  int samples_checked = 0;
  localparam int TB_BIST_CYC = 20;

  // ---------------------------------------------------------------
  // Design, host and clock.
  // ---------------------------------------------------------------
  // A short self-test count keeps the run brief.
  monstat_regs #(.BIST_CYCLES(TB_BIST_CYC)) dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .fault_detect_i(fault), .reset_pin_i(rpin),
    .sequence_enable_0_i(en0), .sequence_enable_1_i(en1), .supply_above_lockout_i(sup),
    .clk_ok_i(clk_ok), .parity_err_i(par), .pd_record_done_i(pd_done),
    .ov_bist_fail_i(ovf), .uv_bist_fail_i(uvf), .ch_monitor_en_o(ch),
    .off_cmp_en_o(off), .bist_active_o(bist));
  monstat_host_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  // Pin changes need several cycles to pass the synchronisers.
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string n);
    logic [7:0] v;
    host.rd(a, v);
    `CHK(n, e, v & m)
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d.", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------
  task automatic t_reset();
    rchk(MONSTAT_MONEN_OFFS, 8'hFF, 8'h7F, "monitor_enable");
    rchk(MONSTAT_STATUS_OFFS, 8'hFC, 8'h14, "status idle");
    rchk(8'h10, 8'hFF, 8'h00, "unmapped");
    host.wr(MONSTAT_STATUS_OFFS, 8'hFF);
    rchk(MONSTAT_STATUS_OFFS, 8'hFC, 8'h14, "status after write");
    `CHK("off_cmp_en", 1'b1, off)
    `CHK("ch_monitor_en", 7'h7F, ch)
    $display("Test reset finished.");
  endtask

  task automatic t_status();
    fault = 1'b1;
    rpin = 1'b0;
    clk_ok = 1'b0;
    par = 1'b1;
    en1 = 1'b1;
    wait_n(8);
    rchk(MONSTAT_STATUS_OFFS, 8'hFC, 8'hEC, "status faults");
    fault = 1'b0;
    rpin = 1'b1;
    clk_ok = 1'b1;
    par = 1'b0;
    en1 = 1'b0;
    wait_n(8);
    rchk(MONSTAT_STATUS_OFFS, 8'hFC, 8'h14, "status clear");
    $display("Test status finished.");
  endtask

  task automatic t_channels();
    host.wr(MONSTAT_MONEN_OFFS, 8'h55);
    wait_n(2);
    `CHK("ch_monitor_en", 7'h55, ch)
    rchk(MONSTAT_MONEN_OFFS, 8'hFF, 8'h55, "monitor_enable");
    $display("Test channels finished.");
  endtask

  task automatic t_power_down();
    host.wr(MONSTAT_MONEN_OFFS, 8'hFF);
    en0 = 1'b0;
    wait_n(10);
    `CHK("off_cmp_en recording", 1'b1, off)
    pd_done = 1'b1;
    wait_n(10);
    `CHK("off_cmp_en down", 1'b0, off)
    `CHK("ch_monitor_en down", 7'h00, ch)
    en0 = 1'b1;
    wait_n(10);
    `CHK("off_cmp_en wake", 1'b1, off)
    `CHK("ch_monitor_en wake", 7'h7F, ch)
    host.wr(MONSTAT_MONEN_OFFS, 8'h7F);
    en0 = 1'b0;
    wait_n(10);
    `CHK("off_cmp_en kept", 1'b1, off)
    `CHK("ch_monitor_en kept", 7'h7F, ch)
    en0 = 1'b1;
    pd_done = 1'b0;
    wait_n(8);
    $display("Test power-down finished.");
  endtask

  // Self-test results are only taken at the end of a run.
  task automatic t_bist(input logic o, input logic u, input logic [7:0] e);
    int n;
    sup = 1'b0;
    wait_n(6);
    ovf = o;
    uvf = u;
    sup = 1'b1;
    for (n = 0; n < 20 && bist !== 1'b1; n++) wait_n(1);
    `CHK("bist_active", 1'b1, bist)
    for (n = 0; n < 40 && bist !== 1'b0; n++) wait_n(1);
    `CHK("bist_active end", 1'b0, bist)
    `CHK("bist_active cycles", TB_BIST_CYC, n)
    rchk(MONSTAT_STATUS_OFFS, 8'h03, e, "selftest bits");
    $display("Test self-test finished.");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog.
  // ---------------------------------------------------------------
  initial
  begin
    {rst_n_i, fault, en1, par, pd_done, ovf, uvf, sup} = 8'h00;
    {rpin, en0, clk_ok} = 3'b111;
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    wait_n(8);
    t_reset();
    t_status();
    t_channels();
    t_power_down();
    t_bist(1'b1, 1'b0, 8'h02);
    t_bist(1'b0, 1'b1, 8'h01);
    wrap_up();
  end

  // The tests need under three hundred cycles; this limit of 20000 cycles leaves ample margin.
  initial
  begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule // monstat_regs_tb_top
